// >>> hdl/gtl_core.sv
// Module: register-level talker/listener core for the IEEE 488 bus
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (R01) Dual primary addressing enable bit
// (R02) Separate talker and listener disable bits
// (R03) Five-bit primary address compared on bus
// (R04) Reset or rst with set bit idles
// (R05) Address switches copied while in reset
// (R06) Rst with clear bit releases reset
// (R07) Serial poll byte returned when polled
// (R08) Request-service bit drives SRQ, marks poll
// (R09) Unhandled commands passed to host register
// (R10) Parallel poll pattern driven during poll
// (R11) Data in captured only while listener
// (R12) NRFD held after byte until read
// (R13) Reading data in releases NRFD itself
// (R14) Transmit byte driven onto data lines
// (R15) No new handshake until new byte
// (R16) New byte permits DAV again
// (R17) Aux set bit one sets, zero clears
// (R18) Data line N maps to bit N
module gtl_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Address switches
	input wire logic [7:0] addr_switch_i,
	// Bus lines, true level high (inverted at the transceiver)
	input wire logic [7:0] dio_i,
	output logic [7:0] dio_o,
	output logic dio_oe_o,
	input wire logic atn_i,
	input wire logic eoi_i,
	input wire logic dav_i,
	output logic dav_o,
	input wire logic nrfd_i,
	output logic nrfd_o,
	input wire logic ndac_i,
	output logic ndac_o,
	output logic srq_o,
	// Interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// State

	// All state in one struct
	typedef struct packed {
		logic [2:0][7:0] sync;           // Data line synchroniser
		logic [2:0][3:0] ctl;            // ATN, EOI, DAV, NRFD synchroniser
		logic [2:0] ndacs;               // NDAC synchroniser
		logic [7:0] dio_s;               // Accepted data lines
		logic [3:0] ctl_s;               // Accepted control lines
		logic ndac_s;                    // Accepted NDAC
		logic in_reset;                  // Held in idle reset
		logic [7:0] adr;                 // Device address register
		logic [7:0] spoll;               // Serial poll status
		logic [7:0] ppoll;               // Parallel poll response
		logic [7:0] cpt;                 // Unhandled command
		logic [7:0] din;                 // Received byte
		logic [7:0] dout;                // Transmit byte
		logic nba;                       // New byte available
		logic lacs;                      // Listener addressed
		logic tacs;                      // Talker addressed
		logic spms;                      // Serial poll mode
		gtl_pkg::gtl_ah_e ah;            // Acceptor state
		gtl_pkg::gtl_sh_e sh;            // Source state
		logic [gtl_pkg::IRQ_W-1:0] ists; // Sticky interrupt status
		logic [gtl_pkg::IRQ_W-1:0] imsk; // Interrupt mask
		logic [7:0] rdata;               // Read data
		logic [7:0] dio;                 // Driven data lines
		logic dio_oe;                    // Data line enable
		logic dav;                       // DAV drive
		logic nrfd;                      // NRFD drive
		logic ndac;                      // NDAC drive
		logic srq;                       // SRQ drive
		logic irq;                       // Interrupt output
	} gtl_state_s;

	gtl_state_s s_q;
	gtl_state_s s_d;

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Helpers, declared here since the process uses blocking temporaries
	logic [7:0] sw_d;
	logic [7:0] sw_q;
	logic [3:0] ct_d;
	logic [3:0] ct_q;
	logic atn;
	logic eoi;
	logic dav_in;
	logic nrfd_in;
	logic my_pri;
	logic [gtl_pkg::IRQ_W-1:0] ev;
	logic aux_wr;

	// Combinational next state of the whole core
	always_comb begin
		s_d = s_q;
		ev = '0;
		// Three-stage synchronisers; only stages 2 and 3 are compared
		s_d.sync[0] = dio_i;
		s_d.sync[1] = s_q.sync[0];
		s_d.sync[2] = s_q.sync[1];
		s_d.ctl[0] = {atn_i, eoi_i, dav_i, nrfd_i};
		s_d.ctl[1] = s_q.ctl[0];
		s_d.ctl[2] = s_q.ctl[1];
		s_d.ndacs = {s_q.ndacs[1:0], ndac_i};
		sw_d = s_q.sync[1];
		sw_q = s_q.sync[2];
		ct_d = s_q.ctl[1];
		ct_q = s_q.ctl[2];
		// A change counts once stages two and three agree
		if (sw_d == sw_q) begin
			s_d.dio_s = sw_q;
		end
		if (ct_d == ct_q) begin
			s_d.ctl_s = ct_q;
		end
		if (s_q.ndacs[1] == s_q.ndacs[2]) begin
			s_d.ndac_s = s_q.ndacs[2];
		end
		atn = s_q.ctl_s[3];
		eoi = s_q.ctl_s[2];
		dav_in = s_q.ctl_s[1];
		nrfd_in = s_q.ctl_s[0];
		// Primary address match; dual mode ignores the low bit
		my_pri = s_q.adr[gtl_pkg::ADR_EDPA_BIT] ? // R01
			(s_q.dio_s[4:1] == s_q.adr[4:1]) :
			(s_q.dio_s[4:0] == s_q.adr[4:0]); // R03
		aux_wr = reg_wr_i && (reg_addr_i == gtl_pkg::ADDR_AUX_CMD);

		// Register reads, default answer zero
		s_d.rdata = gtl_pkg::RST_BYTE;
		if (reg_rd_i) begin
			if (reg_addr_i == gtl_pkg::ADDR_UNHANDLED_CMD) begin
				s_d.rdata = s_q.cpt; // R09
			end else if (reg_addr_i == gtl_pkg::ADDR_RECEIVED_BYTE) begin
				s_d.rdata = s_q.din;
			end else if (reg_addr_i == gtl_pkg::ADDR_IRQ_STATUS) begin
				s_d.rdata = 8'(s_q.ists);
			end else if (reg_addr_i == gtl_pkg::ADDR_IRQ_MASK) begin
				s_d.rdata = 8'(s_q.imsk);
			end else if (reg_addr_i == gtl_pkg::ADDR_CORE_STATUS) begin
				s_d.rdata = {3'h0, s_q.in_reset, s_q.spms, s_q.nba, s_q.tacs, s_q.lacs};
			end
		end

		// Register writes
		if (reg_wr_i) begin
			if (reg_addr_i == gtl_pkg::ADDR_DEVICE_BUS_ADDRESS) begin
				s_d.adr = reg_wdata_i;
			end else if (reg_addr_i == gtl_pkg::ADDR_SERIAL_POLL_STATUS) begin
				s_d.spoll = reg_wdata_i; // R07
			end else if (reg_addr_i == gtl_pkg::ADDR_PARALLEL_POLL) begin
				s_d.ppoll = reg_wdata_i;
			end else if (reg_addr_i == gtl_pkg::ADDR_TRANSMIT_BYTE) begin
				s_d.dout = reg_wdata_i;
				s_d.nba = 1'b1; // R16
			end else if (reg_addr_i == gtl_pkg::ADDR_IRQ_MASK) begin
				s_d.imsk = reg_wdata_i[gtl_pkg::IRQ_W-1:0];
			end
		end

		// Chip reset auxiliary command: set bit enters, clear bit leaves
		if (aux_wr && reg_wdata_i[4:0] == gtl_pkg::AUX_FN_RST) begin
			s_d.in_reset = reg_wdata_i[gtl_pkg::AUX_CS_BIT]; // R17 R06
		end

		// Acceptor handshake with ATN commands and listener data
		case (s_q.ah)
			gtl_pkg::GTL_AH_IDLE: begin
				if (atn || s_q.lacs) begin
					s_d.ah = gtl_pkg::GTL_AH_READY;
				end
			end
			gtl_pkg::GTL_AH_READY: begin
				if (!(atn || s_q.lacs)) begin
					s_d.ah = gtl_pkg::GTL_AH_IDLE;
				end else if (dav_in) begin
					s_d.ah = gtl_pkg::GTL_AH_ACCEPT;
					if (atn) begin
						// Address and command decode
						if (s_q.dio_s[6:5] == gtl_pkg::CMD_GRP_LISTEN) begin
							if (s_q.dio_s[4:0] == gtl_pkg::CMD_UNADDRESS) begin
								s_d.lacs = 1'b0;
							end else if (my_pri && !s_q.adr[gtl_pkg::ADR_DAL_BIT]) begin
								s_d.lacs = 1'b1; // R02
								ev[gtl_pkg::IRQ_MA_BIT] = 1'b1;
							end
						end else if (s_q.dio_s[6:5] == gtl_pkg::CMD_GRP_TALK) begin
							if (my_pri && !s_q.adr[gtl_pkg::ADR_DAT_BIT]) begin
								s_d.tacs = 1'b1; // R02
								ev[gtl_pkg::IRQ_MA_BIT] = 1'b1;
							end else begin
								s_d.tacs = 1'b0;
							end
						end else if (s_q.dio_s[6:0] == gtl_pkg::CMD_SPE) begin
							s_d.spms = 1'b1;
						end else if (s_q.dio_s[6:0] == gtl_pkg::CMD_SPD) begin
							s_d.spms = 1'b0;
						end else begin
							// Not handled here: hand to host
							s_d.cpt = s_q.dio_s; // R09
							ev[gtl_pkg::IRQ_CPT_BIT] = 1'b1;
						end
					end else begin
						// Listener data byte, line N to bit N
						s_d.din = s_q.dio_s; // R11 R18
						ev[gtl_pkg::IRQ_BI_BIT] = 1'b1;
					end
				end
			end
			gtl_pkg::GTL_AH_ACCEPT: begin
				// Wait for DAV false; data bytes then hold off
				if (!dav_in) begin
					s_d.ah = atn ? gtl_pkg::GTL_AH_IDLE : gtl_pkg::GTL_AH_HOLD; // R12
				end
			end
			default: begin
				// Holdoff until the host reads the byte
				if (reg_rd_i && reg_addr_i == gtl_pkg::ADDR_RECEIVED_BYTE) begin
					s_d.ah = gtl_pkg::GTL_AH_IDLE; // R13
				end
			end
		endcase
		s_d.nrfd = (s_q.ah != gtl_pkg::GTL_AH_READY) && (s_q.ah != gtl_pkg::GTL_AH_IDLE); // R12
		s_d.ndac = (s_q.ah == gtl_pkg::GTL_AH_READY); // Idle acceptor leaves lines released

		// Source handshake, only as addressed talker
		case (s_q.sh)
			gtl_pkg::GTL_SH_IDLE: begin
				if ((s_q.tacs && !atn) && (s_q.nba || s_q.spms)) begin
					s_d.sh = gtl_pkg::GTL_SH_WAIT_RFD; // R15
				end
			end
			gtl_pkg::GTL_SH_WAIT_RFD: begin
				if (atn || !s_q.tacs) begin
					s_d.sh = gtl_pkg::GTL_SH_IDLE;
				end else if (!nrfd_in) begin
					s_d.sh = gtl_pkg::GTL_SH_DAV; // R16
				end
			end
			gtl_pkg::GTL_SH_DAV: begin
				if (!s_q.ndac_s) begin
					s_d.sh = gtl_pkg::GTL_SH_DONE;
					if (!s_q.spms) begin
						s_d.nba = 1'b0; // R15
					end
					ev[gtl_pkg::IRQ_BO_BIT] = 1'b1;
				end
			end
			default: begin
				s_d.sh = gtl_pkg::GTL_SH_IDLE;
			end
		endcase
		// Data lines: status byte in poll, pattern in parallel poll, else byte
		if (s_q.spms) begin
			s_d.dio = s_q.spoll; // R07 R08
		end else if (atn && eoi) begin
			s_d.dio = s_q.ppoll; // R10
		end else begin
			s_d.dio = s_q.dout; // R14
		end
		s_d.dio_oe = (s_q.sh != gtl_pkg::GTL_SH_IDLE) || (atn && eoi);
		s_d.dav = (s_d.sh == gtl_pkg::GTL_SH_DAV);
		// SRQ follows the request-service bit outside a poll
		s_d.srq = s_q.spoll[gtl_pkg::SP_RSV_BIT] && !s_q.spms; // R08

		// Sticky status: set wins over write-one-to-clear
		if (reg_wr_i && reg_addr_i == gtl_pkg::ADDR_IRQ_STATUS) begin
			s_d.ists = s_q.ists & ~reg_wdata_i[gtl_pkg::IRQ_W-1:0];
		end
		s_d.ists = s_d.ists | ev;
		s_d.irq = |(s_d.ists & s_d.imsk);

		// Idle reset: bus side quiet, switches copied in
		if (s_d.in_reset) begin
			s_d.adr = addr_switch_i; // R05
			s_d.lacs = 1'b0; // R04
			s_d.tacs = 1'b0;
			s_d.spms = 1'b0;
			s_d.nba = 1'b0;
			s_d.ah = gtl_pkg::GTL_AH_IDLE;
			s_d.sh = gtl_pkg::GTL_SH_IDLE;
			s_d.dio_oe = 1'b0;
			s_d.dav = 1'b0;
			s_d.nrfd = 1'b0;
			s_d.ndac = 1'b0;
			s_d.srq = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Power-up reset holds the idle reset state
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.in_reset <= 1'b1; // R04
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_o = s_q.rdata;
	assign dio_o = s_q.dio;
	assign dio_oe_o = s_q.dio_oe;
	assign dav_o = s_q.dav;
	assign nrfd_o = s_q.nrfd;
	assign ndac_o = s_q.ndac;
	assign srq_o = s_q.srq;
	assign irq_o = s_q.irq;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	// Held reset keeps copying the switches
	property p_sw_copy; // R05
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.in_reset && $stable(addr_switch_i) |=> s_q.adr == $past(addr_switch_i);
	endproperty
	a_sw_copy: assert property (p_sw_copy) else $error("address not copied in reset"); // R05

	// Reset idles the handshake drives
	property p_idle; // R04
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.in_reset |-> !dav_o && !nrfd_o && !ndac_o && !srq_o && !dio_oe_o;
	endproperty
	a_idle: assert property (p_idle) else $error("lines active in reset"); // R04

	// Rst with clear bit leaves reset next cycle
	property p_release; // R06
		@(posedge clk_i) disable iff (!arst_n_i)
		reg_wr_i && reg_addr_i == gtl_pkg::ADDR_AUX_CMD && reg_wdata_i == 8'h00
			|=> !s_q.in_reset;
	endproperty
	a_release: assert property (p_release) else $error("reset not released"); // R06

	// Holdoff stays until a data read
	sequence s_hold_norel;
		s_q.ah == gtl_pkg::GTL_AH_HOLD &&
			!(reg_rd_i && reg_addr_i == gtl_pkg::ADDR_RECEIVED_BYTE) && !s_d.in_reset;
	endsequence
	property p_hold; // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		s_hold_norel |=> s_q.ah == gtl_pkg::GTL_AH_HOLD ##1 nrfd_o;
	endproperty
	a_hold: assert property (p_hold) else $error("holdoff lost"); // R12

	// Data read during holdoff frees the acceptor
	property p_read_rel; // R13
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.ah == gtl_pkg::GTL_AH_HOLD && reg_rd_i && reg_addr_i == gtl_pkg::ADDR_RECEIVED_BYTE
			|=> s_q.ah == gtl_pkg::GTL_AH_IDLE;
	endproperty
	a_read_rel: assert property (p_read_rel) else $error("holdoff not released"); // R13

	// Source leaves idle only with a new byte or in serial poll
	property p_nba; // R15
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.sh == gtl_pkg::GTL_SH_IDLE && !s_q.nba && !s_q.spms
			|=> s_q.sh == gtl_pkg::GTL_SH_IDLE;
	endproperty
	a_nba: assert property (p_nba) else $error("handshake without new byte"); // R15

	// SRQ follows rsv outside poll and reset
	property p_srq; // R08
		@(posedge clk_i) disable iff (!arst_n_i)
		!s_q.in_reset && !s_q.spms && !s_d.in_reset ##0 !s_d.spms
			|=> srq_o == $past(s_q.spoll[gtl_pkg::SP_RSV_BIT]);
	endproperty
	a_srq: assert property (p_srq) else $error("srq mismatch"); // R08

	// Listener data lands in the received byte
	property p_din; // R11
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.ah == gtl_pkg::GTL_AH_READY && dav_in && !atn && s_q.lacs && !s_d.in_reset
			|=> s_q.din == $past(s_q.dio_s);
	endproperty
	a_din: assert property (p_din) else $error("data byte not captured"); // R11

endmodule : gtl_core

`default_nettype wire

// >>> shared/gtl_pkg.sv
// Package: register map, field positions, reset values and encodings of the bus adapter core
package gtl_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] ADDR_DEVICE_BUS_ADDRESS = 4'h0;
	localparam logic [3:0] ADDR_SERIAL_POLL_STATUS = 4'h1;
	localparam logic [3:0] ADDR_UNHANDLED_CMD = 4'h2;
	localparam logic [3:0] ADDR_PARALLEL_POLL = 4'h3;
	localparam logic [3:0] ADDR_RECEIVED_BYTE = 4'h4;
	localparam logic [3:0] ADDR_TRANSMIT_BYTE = 4'h5;
	localparam logic [3:0] ADDR_AUX_CMD = 4'h6;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
	localparam logic [3:0] ADDR_CORE_STATUS = 4'h9;

	// Address register fields
	localparam int ADR_EDPA_BIT = 7;
	localparam int ADR_DAL_BIT = 6;
	localparam int ADR_DAT_BIT = 5;
	localparam int ADR_PRI_LSB = 0;
	localparam int ADR_PRI_W = 5;

	// Serial poll request-service bit position
	localparam int SP_RSV_BIT = 6;

	// Auxiliary command fields
	localparam int AUX_CS_BIT = 7;
	localparam logic [4:0] AUX_FN_RST = 5'h00;

	// Interrupt status bits
	localparam int IRQ_BI_BIT = 0;
	localparam int IRQ_BO_BIT = 1;
	localparam int IRQ_CPT_BIT = 2;
	localparam int IRQ_MA_BIT = 3;
	localparam int IRQ_W = 4;

	// Bus command encodings on the data lines while ATN is true
	localparam logic [1:0] CMD_GRP_LISTEN = 2'h1;
	localparam logic [1:0] CMD_GRP_TALK = 2'h2;
	localparam logic [1:0] CMD_GRP_SECONDARY = 2'h3;
	localparam logic [4:0] CMD_UNADDRESS = 5'h1f;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

	// Acceptor handshake states, Gray along the usual path
	typedef enum logic [1:0] {
		GTL_AH_IDLE = 2'b00,
		GTL_AH_READY = 2'b01,
		GTL_AH_ACCEPT = 2'b11,
		GTL_AH_HOLD = 2'b10
	} gtl_ah_e;

	// Source handshake states, Gray along the usual path
	typedef enum logic [1:0] {
		GTL_SH_IDLE = 2'b00,
		GTL_SH_WAIT_RFD = 2'b01,
		GTL_SH_DAV = 2'b11,
		GTL_SH_DONE = 2'b10
	} gtl_sh_e;

endpackage : gtl_pkg

// >>> dv/gtl_bus_partner.sv
// Behavioural model of another instrument on the bus, true level high
`timescale 1ns/100ps
`default_nettype none

module gtl_bus_partner (
	// Clock
	input wire logic clk_i,
	// Wire levels seen on the bus
	input wire logic [7:0] dio_i,
	input wire logic dav_i,
	input wire logic nrfd_i,
	input wire logic ndac_i,
	// Lines driven by this instrument
	output logic [7:0] dio_o,
	output logic atn_o,
	output logic eoi_o,
	output logic dav_o,
	output logic nrfd_o,
	output logic ndac_o
);
	int n; // Bounded wait counter

	// Released lines read false; acceptor idles not ready, so no talker can run unseen
	initial begin
		dio_o = 8'h00;
		atn_o = 1'b0;
		eoi_o = 1'b0;
		dav_o = 1'b0;
		nrfd_o = 1'b1;
		ndac_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source handshake: DAV once every acceptor is ready or a 200-cycle wait runs out
	task send(input logic a, input logic [7:0] b);
		@(posedge clk_i);
		atn_o <= a;
		dio_o <= b;
		nrfd_o <= 1'b0;
		ndac_o <= 1'b0;
		// Settling time: acceptors see ATN only through their synchronisers
		repeat (8) @(posedge clk_i);
		for (n = 0; n < 200 && nrfd_i !== 1'b0; n++) @(posedge clk_i);
		@(posedge clk_i);
		dav_o <= 1'b1;
		for (n = 0; n < 200 && ndac_i !== 1'b0; n++) @(posedge clk_i);
		dav_o <= 1'b0;
		dio_o <= 8'h00;
		// Let the acceptor see DAV false before ATN moves
		for (n = 0; n < 12 && ndac_i !== 1'b1; n++) @(posedge clk_i);
		@(posedge clk_i);
		atn_o <= 1'b0;
		nrfd_o <= 1'b1;
		ndac_o <= 1'b1;
	endtask : send

	////////////////////////////////////////////////////////////////////////////////
	// Acceptor handshake; got stays low if nothing is offered within lim cycles
	task accept(input int lim, output logic [7:0] b, output logic got);
		@(posedge clk_i);
		nrfd_o <= 1'b0;
		for (n = 0; n < lim && dav_i !== 1'b1; n++) @(posedge clk_i);
		got = (dav_i === 1'b1);
		b = dio_i;
		nrfd_o <= 1'b1;
		if (got) begin
			ndac_o <= 1'b0;
			for (n = 0; n < 200 && dav_i !== 1'b0; n++) @(posedge clk_i);
			@(posedge clk_i);
			ndac_o <= 1'b1;
		end
	endtask : accept

	// Parallel poll: ATN and EOI together
	task ppoll(input logic on);
		@(posedge clk_i);
		atn_o <= on;
		eoi_o <= on;
	endtask : ppoll

endmodule : gtl_bus_partner
`default_nettype wire

// >>> dv/tb_gtl_core.sv
// Self-checking bench for the bus adapter register core
`timescale 1ns/100ps
`default_nettype none

module tb_gtl_core;
	logic clk = 1'b0; // 20 MHz bench clock
	logic arst_n = 1'b0; // Reset, active low
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] sw = 8'h0a; // Address switches
	logic [7:0] rdata, d_dio, p_dio, v;
	logic d_oe, d_dav, d_nrfd, d_ndac, srq, irq, atn, eoi, p_dav, p_nrfd, p_ndac, got;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	// Wired bus: a true level from either party wins
	wire logic [7:0] dio_w = (d_oe ? d_dio : 8'h00) | p_dio;
	wire logic dav_w = d_dav | p_dav;
	wire logic nrfd_w = d_nrfd | p_nrfd;
	wire logic ndac_w = d_ndac | p_ndac;

	always #25 clk = ~clk;

	gtl_core dut (.clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .addr_switch_i(sw), .dio_i(dio_w),
		.dio_o(d_dio), .dio_oe_o(d_oe), .atn_i(atn), .eoi_i(eoi), .dav_i(dav_w), .dav_o(d_dav),
		.nrfd_i(nrfd_w), .nrfd_o(d_nrfd), .ndac_i(ndac_w), .ndac_o(d_ndac), .srq_o(srq),
		.irq_o(irq));

	gtl_bus_partner p (.clk_i(clk), .dio_i(dio_w), .dav_i(dav_w), .nrfd_i(nrfd_w),
		.ndac_i(ndac_w), .dio_o(p_dio), .atn_o(atn), .eoi_o(eoi), .dav_o(p_dav),
		.nrfd_o(p_nrfd), .ndac_o(p_ndac));

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One-cycle write strobe
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rdchk

	// Wait, then let the edge's updates land
	task idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : idle

	task results;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// Hang guard, far above the several hundred cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		idle(4);
		arst_n <= 1'b1;
		// Idle reset until released, re-entered by set bit
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h10);
		wr_reg(gtl_pkg::ADDR_AUX_CMD, 8'h00);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h00);
		sw <= 8'h0b;
		wr_reg(gtl_pkg::ADDR_AUX_CMD, 8'h80);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h10);
		wr_reg(gtl_pkg::ADDR_AUX_CMD, 8'h00);
		// Listen address taken from the new switch value
		p.send(1'b1, 8'h2b);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h01);
		p.send(1'b0, 8'ha5);
		idle(10);
		chk({7'h00, d_nrfd}, 8'h01);
		rdchk(gtl_pkg::ADDR_RECEIVED_BYTE, 8'ha5);
		idle(4);
		chk({7'h00, d_nrfd}, 8'h00);
		// Interrupt raised, masked and cleared
		rdchk(gtl_pkg::ADDR_IRQ_STATUS, 8'h09);
		wr_reg(gtl_pkg::ADDR_IRQ_MASK, 8'h01);
		idle(2);
		chk({7'h00, irq}, 8'h01);
		wr_reg(gtl_pkg::ADDR_IRQ_STATUS, 8'h0f);
		idle(2);
		chk({7'h00, irq}, 8'h00);
		wr_reg(gtl_pkg::ADDR_IRQ_MASK, 8'h00);
		// Unaddressed: bytes pass by uncaptured
		p.send(1'b1, 8'h3f);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h00);
		p.send(1'b0, 8'h5a);
		rdchk(gtl_pkg::ADDR_RECEIVED_BYTE, 8'ha5);
		chk({6'h00, d_nrfd, d_ndac}, 8'h00);
		// Listen disable, then dual addressing ignores the low bit
		wr_reg(gtl_pkg::ADDR_DEVICE_BUS_ADDRESS, 8'h4b);
		p.send(1'b1, 8'h2b);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h00);
		wr_reg(gtl_pkg::ADDR_DEVICE_BUS_ADDRESS, 8'h8a);
		p.send(1'b1, 8'h2b);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h01);
		p.send(1'b1, 8'h3f);
		p.send(1'b1, 8'h01);
		rdchk(gtl_pkg::ADDR_UNHANDLED_CMD, 8'h01);
		// Talk disable, then talker
		wr_reg(gtl_pkg::ADDR_DEVICE_BUS_ADDRESS, 8'h2b);
		p.send(1'b1, 8'h4b);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h00);
		wr_reg(gtl_pkg::ADDR_DEVICE_BUS_ADDRESS, 8'h0b);
		p.send(1'b1, 8'h4b);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h02);
		// Serial poll returns the status byte with the service bit
		wr_reg(gtl_pkg::ADDR_SERIAL_POLL_STATUS, 8'h45);
		idle(2);
		chk({7'h00, srq}, 8'h01);
		p.send(1'b1, 8'h18);
		p.accept(200, v, got);
		chk(v, 8'h45);
		chk({7'h00, got}, 8'h01);
		p.send(1'b1, 8'h19);
		wr_reg(gtl_pkg::ADDR_SERIAL_POLL_STATUS, 8'h05);
		idle(2);
		chk({7'h00, srq}, 8'h00);
		// One handshake per written byte
		wr_reg(gtl_pkg::ADDR_TRANSMIT_BYTE, 8'h3c);
		p.accept(200, v, got);
		chk(v, 8'h3c);
		chk({7'h00, got}, 8'h01);
		rdchk(gtl_pkg::ADDR_CORE_STATUS, 8'h02);
		p.accept(60, v, got);
		chk({7'h00, got}, 8'h00);
		wr_reg(gtl_pkg::ADDR_TRANSMIT_BYTE, 8'hc3);
		p.accept(200, v, got);
		chk(v, 8'hc3);
		chk({7'h00, got}, 8'h01);
		// Parallel poll pattern on the data lines
		wr_reg(gtl_pkg::ADDR_PARALLEL_POLL, 8'h96);
		p.ppoll(1'b1);
		idle(10);
		chk(dio_w, 8'h96);
		chk({7'h00, d_oe}, 8'h01);
		p.ppoll(1'b0);
		idle(10);
		chk({7'h00, d_oe}, 8'h00);
		// Unmapped and write-only places read zero
		rdchk(4'hf, 8'h00);
		rdchk(gtl_pkg::ADDR_DEVICE_BUS_ADDRESS, 8'h00);
		results();
	end

endmodule : tb_gtl_core
`default_nettype wire
